// ===== test/cas_core_drv.sv
// partner model: core execution side issuing one arithmetic request per op
`timescale 1ns/1ns
`default_nettype none
module cas_core_drv (
    input  wire logic                 clk_i,
    output var cas_pkg::cas_alu_req_t alu_o
);
    import cas_pkg::*;
    initial alu_o = '0;
    // valid is a single-cycle pulse, so the op is never taken twice
    task automatic issue(input cas_op_t op, input logic [7:0] x);
        @(posedge clk_i);
        alu_o <= '{valid: 1'b1, op: op, operand: x};
        @(posedge clk_i);
        alu_o <= '0;
        #1;
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the accumulator and status word block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cas_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    cas_sfr_req_t sfr   = '0;
    cas_alu_req_t alu;
    logic [7:0]   rd_data_o, primary_o, second_o, status_o;
    logic [4:0]   bank_base_o;
    int           n_mismatch = 0;
    int           n_checks   = 0;
    logic [31:0]  seed       = 32'h52;
    logic [7:0]   m_acc, m_b, m_psw;
    always #25 clk_i = ~clk_i;
    cas_core_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr), .alu_i(alu), .rd_data_o(rd_data_o),
                       .primary_o(primary_o), .second_o(second_o), .status_o(status_o), .bank_base_o(bank_base_o));
    cas_core_drv PM (.clk_i(clk_i), .alu_o(alu));
    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic sfr_op(input logic [7:0] a, input logic r, w, b, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_i);
        sfr <= '{addr: a, rd: r, wr: w, wdata: d, bit_wr: b, bit_sel: s, bit_val: d[0]};
        @(posedge clk_i);
        sfr <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_op(a, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        chk("read", rd_data_o, exp);
    endtask
    // byte write when b is low, single-bit write of d[0] otherwise
    task automatic sw(input logic [7:0] a, input logic b, input logic [2:0] s, input logic [7:0] d);
        logic [7:0] v;
        sfr_op(a, 1'b0, ~b, b, s, d);
        v = (a == CAS_ADDR_STATUS) ? m_psw : (a == CAS_ADDR_PRIMARY) ? m_acc : m_b;
        if (b) v[s] = d[0];
        else v = d;
        if (a == CAS_ADDR_STATUS) m_psw = v & 8'hfe;
        else if (a == CAS_ADDR_PRIMARY) m_acc = v;
        else if (a == CAS_ADDR_SECOND) m_b = v;
    endtask
    task automatic cmp_all();
        chk("primary", primary_o, m_acc);
        chk("second", second_o, m_b);
        chk("status", status_o, {m_psw[7:1], ^m_acc});
        chk("bank", {3'h0, bank_base_o}, {3'h0, m_psw[4:3], 3'h0});
    endtask
    task automatic alu_step(input cas_op_t op, input logic [7:0] x);
        int a, xi, r, c, h;
        PM.issue(op, x);
        a = m_acc;
        xi = x;
        c = (op == CAS_OP_ADD) ? 0 : m_psw[7];
        h = 0;
        case (op)
            CAS_OP_ADD, CAS_OP_ADDC: begin
                r = a + xi + c;
                h = ((a % 16) + (xi % 16) + c) > 15;
                m_psw[2] = (a[7] == xi[7]) && (r[7] != a[7]);
                c = r > 255;
            end
            CAS_OP_SUBB: begin
                r = a - xi - c;
                h = (a % 16) < ((xi % 16) + c);
                m_psw[2] = (a[7] != xi[7]) && (r[7] != a[7]);
                c = r < 0;
            end
            CAS_OP_MUL: begin
                r = a * m_b;
                m_b = r / 256;
                m_psw[2] = r > 255;
                c = 0;
            end
            default: begin
                r = a;
                c = 0;
                m_psw[2] = (m_b == 0);
                if (m_b != 0) begin
                    r = a / m_b;
                    m_b = a % m_b;
                end
            end
        endcase
        m_acc = r[7:0];
        m_psw[7] = c[0];
        m_psw[6] = h[0];
        chk("flags", status_o & 8'hc4, m_psw & 8'hc4);
        cmp_all();
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        m_acc = 8'h00;
        m_b = 8'h00;
        m_psw = 8'h00;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        cmp_all();
        rd(CAS_ADDR_STATUS, CAS_RST_STATUS);
        rd(CAS_ADDR_PRIMARY, CAS_RST_PRIMARY);
        rd(CAS_ADDR_SECOND, CAS_RST_SECOND);
        $display("test reset done");
        sw(CAS_ADDR_PRIMARY, 1'b0, 3'h0, 8'h5a);
        rd(CAS_ADDR_PRIMARY, 8'h5a);
        sw(CAS_ADDR_PRIMARY, 1'b1, 3'h0, 8'h01);
        rd(CAS_ADDR_PRIMARY, 8'h5b);
        sw(CAS_ADDR_SECOND, 1'b1, 3'h7, 8'h01);
        rd(CAS_ADDR_SECOND, 8'h80);
        rd(8'hd1, CAS_RD_UNMAPPED);
        for (int i = 0; i < 4; i++) begin
            sw(CAS_ADDR_STATUS, 1'b0, 3'h0, 8'h23 | 8'(i << CAS_BANK_SHIFT));
            cmp_all();
            rd(CAS_ADDR_STATUS, {m_psw[7:1], ^m_acc});
        end
        sw(CAS_ADDR_STATUS, 1'b1, 3'(CAS_BIT_USER0), 8'h00);
        sw(CAS_ADDR_STATUS, 1'b1, 3'(CAS_BIT_PARITY), 8'h01);
        cmp_all();
        $display("test registers done");
        // edge cases first: carry chain, divide by zero, wide product
        sw(CAS_ADDR_PRIMARY, 1'b0, 3'h0, 8'hff);
        alu_step(CAS_OP_ADD, 8'h01);
        alu_step(CAS_OP_ADDC, 8'h7f);
        sw(CAS_ADDR_SECOND, 1'b0, 3'h0, 8'h00);
        alu_step(CAS_OP_DIV, 8'h00);
        sw(CAS_ADDR_SECOND, 1'b0, 3'h0, 8'h10);
        sw(CAS_ADDR_PRIMARY, 1'b0, 3'h0, 8'h20);
        alu_step(CAS_OP_MUL, 8'h00);
        for (int i = 0; i < 300; i++) begin
            if (xs() % 8 == 0) sw(CAS_ADDR_SECOND, 1'b0, 3'h0, 8'(xs() % 8));
            alu_step(cas_op_t'(3'(xs() % 5)), 8'(xs()));
        end
        cmp_all();
        $display("test arithmetic done");
        // reset again with live values so the clear is seen on nonzero state
        rd(CAS_ADDR_PRIMARY, m_acc);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        m_acc = CAS_RST_PRIMARY;
        m_b = CAS_RST_SECOND;
        m_psw = CAS_RST_STATUS;
        chk("rd_data", rd_data_o, 8'h00);
        cmp_all();
        alu_step(CAS_OP_ADD, 8'h00);
        $display("test mid-run reset done");
        print_verdict();
    end
    initial begin
        #1000000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== verilog/cas_alu_flags.sv
// combinational arithmetic unit producing results and flags
`timescale 1ns/1ns
`default_nettype none
module cas_alu_flags (
    input  wire cas_pkg::cas_alu_req_t req_i,
    input  wire logic [7:0]            primary_i,
    input  wire logic [7:0]            second_i,
    input  wire logic                  carry_i,
    output var cas_pkg::cas_alu_res_t  res_o
);
    import cas_pkg::*;

    logic       cin;
    logic [8:0] wide;
    logic [4:0] nib;
    logic [15:0] prod;

    always_comb begin
        cin = 1'b0;
        wide = 9'h000;
        nib = 5'h00;
        prod = 16'h0000;
        res_o = '0;
        res_o.primary = primary_i;
        res_o.second = second_i;
        unique case (req_i.op)
            CAS_OP_ADD, CAS_OP_ADDC: begin
                cin = (req_i.op == CAS_OP_ADDC) ? carry_i : 1'b0;
                wide = {1'b0, primary_i} + {1'b0, req_i.operand} + {8'h00, cin};
                nib = {1'b0, primary_i[3:0]} + {1'b0, req_i.operand[3:0]} + {4'h0, cin};
                res_o.primary = wide[7:0];
                res_o.carry = wide[8];
                res_o.half = nib[4];
                res_o.range = (primary_i[7] == req_i.operand[7]) && (wide[7] != primary_i[7]);
            end
            CAS_OP_SUBB: begin
                cin = carry_i;
                wide = {1'b0, primary_i} - {1'b0, req_i.operand} - {8'h00, cin};
                nib = {1'b0, primary_i[3:0]} - {1'b0, req_i.operand[3:0]} - {4'h0, cin};
                res_o.primary = wide[7:0];
                res_o.carry = wide[8];
                res_o.half = nib[4];
                res_o.range = (primary_i[7] != req_i.operand[7]) && (wide[7] != primary_i[7]);
            end
            CAS_OP_MUL: begin
                prod = {8'h00, primary_i} * {8'h00, second_i};
                res_o.primary = prod[7:0];
                res_o.second = prod[15:8];
                res_o.write_second = 1'b1;
                res_o.range = |prod[15:8];
            end
            CAS_OP_DIV: begin
                // zero divisor leaves both operands untouched
                if (second_i == 8'h00) begin
                    res_o.range = 1'b1;
                end else begin
                    res_o.primary = primary_i / second_i;
                    res_o.second = primary_i % second_i;
                    res_o.write_second = 1'b1;
                end
            end
            default: begin
                res_o = '0;
                res_o.primary = primary_i;
                res_o.second = second_i;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== verilog/cas_core_regs.sv
// accumulator, second operand and status word registers with flag logic
`timescale 1ns/1ns
`default_nettype none
module cas_core_regs (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire cas_pkg::cas_sfr_req_t sfr_i,
    input  wire cas_pkg::cas_alu_req_t alu_i,
    output logic [7:0]                 rd_data_o,
    output logic [7:0]                 primary_o,
    output logic [7:0]                 second_o,
    output logic [7:0]                 status_o,
    output logic [4:0]                 bank_base_o
);
    import cas_pkg::*;

    // ********************************
    // state
    // ********************************
    logic [7:0]   primary;
    logic [7:0]   second;
    logic [7:0]   status;
    logic [7:0]   rd_data;
    logic [7:0]   next_primary;
    logic [7:0]   next_second;
    logic [7:0]   next_status;
    logic [7:0]   next_rd_data;
    logic         parity;
    logic [7:0]   status_view;
    cas_alu_res_t res;

    cas_alu_flags u_alu (
        .req_i     (alu_i),
        .primary_i (primary),
        .second_i  (second),
        .carry_i   (status[CAS_BIT_CARRY]),
        .res_o     (res)
    );

    // parity is pure logic on the register, so it can never lag it
    assign parity = ^primary;
    always_comb begin
        status_view = status;
        status_view[CAS_BIT_PARITY] = parity;
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        next_primary = primary;
        next_second = second;
        next_status = status;
        next_rd_data = rd_data;
        if (alu_i.valid) begin
            next_primary = res.primary;
            if (res.write_second) begin
                next_second = res.second;
            end
            next_status[CAS_BIT_CARRY] = res.carry;
            next_status[CAS_BIT_HALF] = res.half;
            next_status[CAS_BIT_RANGE] = res.range;
        end
        // software access lands after the arithmetic one, so it wins
        if (sfr_i.wr) begin
            unique case (sfr_i.addr)
                CAS_ADDR_PRIMARY: next_primary = sfr_i.wdata;
                CAS_ADDR_SECOND: next_second = sfr_i.wdata;
                CAS_ADDR_STATUS: next_status = sfr_i.wdata;
                default: begin
                end
            endcase
        end else if (sfr_i.bit_wr) begin
            unique case (sfr_i.addr)
                CAS_ADDR_PRIMARY: next_primary[sfr_i.bit_sel] = sfr_i.bit_val;
                CAS_ADDR_SECOND: next_second[sfr_i.bit_sel] = sfr_i.bit_val;
                CAS_ADDR_STATUS: next_status[sfr_i.bit_sel] = sfr_i.bit_val;
                default: begin
                end
            endcase
        end
        // stored parity slot is never used; the read path substitutes it
        next_status[CAS_BIT_PARITY] = 1'b0;
        if (sfr_i.rd) begin
            unique case (sfr_i.addr)
                CAS_ADDR_PRIMARY: next_rd_data = primary;
                CAS_ADDR_SECOND: next_rd_data = second;
                CAS_ADDR_STATUS: next_rd_data = status_view;
                default: next_rd_data = CAS_RD_UNMAPPED;
            endcase
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primary <= CAS_RST_PRIMARY;
            second <= CAS_RST_SECOND;
            status <= CAS_RST_STATUS;
            rd_data <= 8'h00;
        end else begin
            primary <= next_primary;
            second <= next_second;
            status <= next_status;
            rd_data <= next_rd_data;
        end
    end

    assign rd_data_o = rd_data;
    assign primary_o = primary;
    assign second_o = second;
    assign status_o = status_view;
    assign bank_base_o = {status[CAS_BIT_BANK_HI:CAS_BIT_BANK_LO], 3'h0};

    // ********************************
    // checks
    // ********************************
    logic sw_hits_status;
    assign sw_hits_status = (sfr_i.wr || sfr_i.bit_wr) && sfr_i.addr == CAS_ADDR_STATUS;

    // any software write may override a result register, so data checks skip those cycles
    logic sw_any;
    assign sw_any = sfr_i.wr || sfr_i.bit_wr;

    sequence s_add_op;
        alu_i.valid && alu_i.op == CAS_OP_ADD && !sw_hits_status;
    endsequence
    sequence s_mul_op;
        alu_i.valid && alu_i.op == CAS_OP_MUL && !sw_any;
    endsequence
    sequence s_div_zero;
        alu_i.valid && alu_i.op == CAS_OP_DIV && second == 8'h00 && !sw_any;
    endsequence
    sequence s_sum_op;
        alu_i.valid && (alu_i.op == CAS_OP_ADD || alu_i.op == CAS_OP_ADDC) && !sw_any;
    endsequence
    sequence s_subb_op;
        alu_i.valid && alu_i.op == CAS_OP_SUBB && !sw_hits_status;
    endsequence
    sequence s_div_ok;
        alu_i.valid && alu_i.op == CAS_OP_DIV && second != 8'h00 && !sw_any;
    endsequence
    sequence s_muldiv_op;
        alu_i.valid && (alu_i.op == CAS_OP_MUL || alu_i.op == CAS_OP_DIV) && !sw_hits_status;
    endsequence

    a_reset_clears_all: assert property (@(posedge clk_i)
        rst_i |=> primary_o == 8'h00 && second_o == 8'h00 && status_o == 8'h00)
        else $error("registers not cleared by reset");
    a_parity_tracks_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_i.rd && sfr_i.addr == CAS_ADDR_STATUS |=> rd_data_o[0] == ^$past(primary_o))
        else $error("parity bit disagrees with accumulator");
    a_carry_from_add: assert property (@(posedge clk_i) disable iff (rst_i)
        s_add_op |=> status_o[7] == (({1'b0, $past(primary)} + {1'b0, $past(alu_i.operand)}) > 9'h0ff))
        else $error("carry wrong after add");
    a_half_from_add: assert property (@(posedge clk_i) disable iff (rst_i)
        s_add_op |=> status_o[6] == (({1'b0, $past(primary[3:0])} + {1'b0, $past(alu_i.operand[3:0])}) > 5'h0f))
        else $error("half carry wrong after add");
    a_range_on_mul: assert property (@(posedge clk_i) disable iff (rst_i)
        s_mul_op |=> status_o[2] == (second_o != 8'h00) && !status_o[7])
        else $error("multiply overflow flag wrong");
    a_range_div_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_div_zero |=> status_o[2] && $stable(primary_o) && $stable(second_o))
        else $error("divide by zero not flagged");
    a_user_flags_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !sw_hits_status |=> $stable({status_o[5], status_o[4:3], status_o[1]}))
        else $error("software flags changed by hardware");
    a_bank_base_map: assert property (@(posedge clk_i) disable iff (rst_i)
        bank_base_o == 5'(status_o[4:3] * 8))
        else $error("bank base does not follow select bits");
    a_range_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
        s_mul_op ##1 (second_o == 8'h00) |-> !status_o[2])
        else $error("overflow not cleared");
    a_parity_write_void: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_i.wr && sfr_i.addr == CAS_ADDR_STATUS |=> status_o == {$past(sfr_i.wdata[7:1]), ^primary_o})
        else $error("parity accepted a software write");
    a_borrow_from_subb: assert property (@(posedge clk_i) disable iff (rst_i)
        s_subb_op |=> status_o[7] ==
            ({1'b0, $past(primary)} < ({1'b0, $past(alu_i.operand)} + {8'h00, $past(status_o[7])})))
        else $error("borrow wrong after subtract");
    a_half_from_subb: assert property (@(posedge clk_i) disable iff (rst_i)
        s_subb_op |=> status_o[6] ==
            ({1'b0, $past(primary[3:0])} < ({1'b0, $past(alu_i.operand[3:0])} + {4'h0, $past(status_o[7])})))
        else $error("half borrow wrong after subtract");
    a_range_from_sum: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sum_op |=> status_o[2] ==
            ($past(primary[7]) == $past(alu_i.operand[7]) && primary_o[7] != $past(primary[7])))
        else $error("signed overflow wrong after add");
    a_mul_pairing: assert property (@(posedge clk_i) disable iff (rst_i)
        s_mul_op |=> {second_o, primary_o} == {8'h00, $past(primary)} * {8'h00, $past(second)})
        else $error("product bytes wrong");
    a_range_div_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        s_div_ok |=> !status_o[2] && primary_o == $past(primary) / $past(second) &&
            second_o == $past(primary) % $past(second))
        else $error("divide result or overflow wrong");
    a_flags_clear_muldiv: assert property (@(posedge clk_i) disable iff (rst_i)
        s_muldiv_op |=> !status_o[7] && !status_o[6])
        else $error("carry flags not cleared by multiply or divide");
    a_read_primary: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_i.rd && sfr_i.addr == CAS_ADDR_PRIMARY |=> rd_data_o == $past(primary_o))
        else $error("accumulator read data wrong");
    a_read_second: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_i.rd && sfr_i.addr == CAS_ADDR_SECOND |=> rd_data_o == $past(second_o))
        else $error("second operand read data wrong");
endmodule
`default_nettype wire

// ===== verilog/cas_pkg.sv
// package: offsets, field positions, reset values and carriers of the accumulator block
package cas_pkg;

    // ********************************
    // special function addresses
    // ********************************
    localparam logic [7:0] CAS_ADDR_STATUS = 8'hd0;
    localparam logic [7:0] CAS_ADDR_PRIMARY = 8'he0;
    localparam logic [7:0] CAS_ADDR_SECOND = 8'hf0;

    // ********************************
    // status word field positions
    // ********************************
    localparam int CAS_BIT_CARRY = 7;
    localparam int CAS_BIT_HALF = 6;
    localparam int CAS_BIT_USER0 = 5;
    localparam int CAS_BIT_BANK_HI = 4;
    localparam int CAS_BIT_BANK_LO = 3;
    localparam int CAS_BIT_RANGE = 2;
    localparam int CAS_BIT_USER1 = 1;
    localparam int CAS_BIT_PARITY = 0;

    // ********************************
    // reset values and misc
    // ********************************
    localparam logic [7:0] CAS_RST_STATUS = 8'h00;
    localparam logic [7:0] CAS_RST_PRIMARY = 8'h00;
    localparam logic [7:0] CAS_RST_SECOND = 8'h00;
    localparam logic [7:0] CAS_RD_UNMAPPED = 8'h00;
    localparam int CAS_BANK_SHIFT = 3;

    typedef enum logic [2:0] {
        CAS_OP_ADD  = 3'h0,
        CAS_OP_ADDC = 3'h1,
        CAS_OP_SUBB = 3'h2,
        CAS_OP_MUL  = 3'h3,
        CAS_OP_DIV  = 3'h4
    } cas_op_t;

    typedef struct packed {
        logic       valid;
        cas_op_t    op;
        logic [7:0] operand;
    } cas_alu_req_t;

    typedef struct packed {
        logic [7:0] primary;
        logic [7:0] second;
        logic       write_second;
        logic       carry;
        logic       half;
        logic       range;
    } cas_alu_res_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [2:0] bit_sel;
        logic       bit_val;
    } cas_sfr_req_t;

endpackage
